// ---- event_source.sv ----
module event_source (
   // Clock and event interrupt seen
   input wire logic pclk,
   input wire logic event_irq_q,
   // Event stream
   output logic evt_valid,
   output logic [6:0] evt_code,
   output logic evt_state
);
   timeunit 1ns;
   timeprecision 1ps;
   logic got_irq = 1'b0;
   initial begin
      evt_valid = 1'b0;
      evt_code = 7'h00;
      evt_state = 1'b0;
   end
   // Idle lines are inverted so a stale code can never match
   task send(input logic [6:0] c, input logic s);
      @(posedge pclk);
      evt_valid <= 1'b1;
      evt_code <= c;
      evt_state <= s;
      @(posedge pclk);
      evt_valid <= 1'b0;
      evt_code <= ~c;
      evt_state <= ~s;
      #1 got_irq = event_irq_q;
      @(posedge pclk);
      #1 got_irq = got_irq | event_irq_q;
   endtask
endmodule

// ---- keypad_lock_checker.sv ----
module keypad_lock_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Events and status
   input wire logic evt_valid,
   input wire logic locked_q,
   input wire logic event_irq_q,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   property p_rdy_time; psel && penable && !pready |=> pready; endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("ready late");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_irq_pulse; event_irq_q |=> !event_irq_q; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("event irq not masked");
   property p_irq_cause; event_irq_q |-> $past(evt_valid) && $past(locked_q); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("event irq uncaused");
   property p_lock_cause; $rose(locked_q) |-> $past(evt_valid); endproperty
   a_lock_cause: assert property (p_lock_cause) else $error("lock uncaused");
   property p_open_cause; $fell(locked_q) |-> $past(evt_valid) || $past(psel); endproperty
   a_open_cause: assert property (p_open_cause) else $error("unlock uncaused");
   property p_lock_hold; !evt_valid && !psel |=> $stable(locked_q); endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock moved");
   property p_irq_src; $rose(irq) |-> $past(evt_valid) || $past(psel); endproperty
   a_irq_src: assert property (p_irq_src) else $error("irq uncaused");
   c_lock: cover property ($rose(locked_q));
   c_open: cover property ($fell(locked_q));
   c_evirq: cover property (event_irq_q);
endmodule

// ---- keypad_lock_unlock.v ----
`include "lock_defines.vh"
module keypad_lock_unlock #(
   parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Decoded event stream: code, active(1)/press or inactive(0)/release
   input wire evt_valid,
   input wire [6:0] evt_code,
   input wire evt_state,
   // Lock state
   output reg locked_q,
   // Interrupts
   output reg event_irq_q,
   output reg irq
);
   ////////////////////////////////////////////////////////////////////////////
   localparam S_OPEN = 2'd0;
   localparam S_LOCKED = 2'd1;
   localparam S_HALF = 2'd2;

   reg [7:0] first_release_code_q;
   reg [7:0] second_release_code_q;
   reg [7:0] keypad_freeze_trigger_code_q;
   reg [7:0] freeze_timing_settings_q;
   reg [7:0] freeze_configuration_q;
   reg [3:0] status_q;
   reg [3:0] mask_q;
   reg [1:0] state_q;
   reg [2:0] win_q;
   reg [4:0] mtmr_q;
   reg masking_q;
   wire sec_tick;
   reg tick_restart;

   wire [6:0] first_release_event_code = first_release_code_q[`CODE_MSB:0];
   wire first_release_polarity = first_release_code_q[`POL_BIT];
   wire [6:0] second_release_event_code = second_release_code_q[`CODE_MSB:0];
   wire second_release_polarity = second_release_code_q[`POL_BIT];
   wire [6:0] freeze_trigger_code = keypad_freeze_trigger_code_q[`CODE_MSB:0];
   wire freeze_trigger_polarity = keypad_freeze_trigger_code_q[`POL_BIT];
   wire [4:0] mask_secs = freeze_timing_settings_q[`MASK_MSB:`MASK_LSB];
   wire [2:0] win_secs = freeze_timing_settings_q[`WIN_MSB:`WIN_LSB];
   wire lock_en = freeze_configuration_q[`EN_BIT];

   // Polarity bit selects press/active (1) or release/inactive (0)
   function match;
      input [6:0] code;
      input pol;
      input [6:0] ecode;
      input estate;
      begin
         match = (code == ecode) && (pol == estate);
      end
   endfunction

   function [31:0] word;
      input [7:0] v;
      begin
         word = {24'h00_0000, v};
      end
   endfunction

   wire hit1 = evt_valid && match(first_release_event_code, first_release_polarity,
                                  evt_code, evt_state);
   wire hit2 = evt_valid && match(second_release_event_code, second_release_polarity,
                                  evt_code, evt_state);
   wire hitf = evt_valid && match(freeze_trigger_code, freeze_trigger_polarity,
                                  evt_code, evt_state);
   wire in_lock = (state_q != S_OPEN);

   second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .restart(tick_restart),
      .tick_q(sec_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: ready one cycle after the first access edge, so one wait state
   wire acc = psel && penable;
   wire first_acc = acc && !pready;
   wire [9:0] idx = paddr[11:2];
   wire wr = first_acc && pwrite;
   wire rd_en = first_acc && !pwrite;
   wire mapped = (idx >= {2'b00, `IDX_FIRST_CODE}) && (idx <= {2'b00, `IDX_STATE});
   reg [3:0] ev_set;
   reg event_irq_fire;
   reg unlock_done;
   reg [7:0] rdata_d;

   // Offset decode shared by the read mux, the write strobes and the clear
   wire sel_first = (idx == {2'b00, `IDX_FIRST_CODE});
   wire sel_second = (idx == {2'b00, `IDX_SECOND_CODE});
   wire sel_freeze = (idx == {2'b00, `IDX_FREEZE_CODE});
   wire sel_timing = (idx == {2'b00, `IDX_TIMING});
   wire sel_config = (idx == {2'b00, `IDX_CONFIG});
   wire sel_status = (idx == {2'b00, `IDX_STATUS});
   wire sel_mask = (idx == {2'b00, `IDX_MASK});
   wire sel_state = (idx == {2'b00, `IDX_STATE});

   // Read mux; reserved bits and unknown offsets read as zero
   always @* begin
      rdata_d = 8'h00;
      if (sel_first) begin
         rdata_d = first_release_code_q;
      end
      if (sel_second) begin
         rdata_d = second_release_code_q;
      end
      if (sel_freeze) begin
         rdata_d = keypad_freeze_trigger_code_q;
      end
      if (sel_timing) begin
         rdata_d = freeze_timing_settings_q;
      end
      if (sel_config) begin
         rdata_d = {7'h00, lock_en};
      end
      if (sel_status) begin
         rdata_d = {4'h0, status_q};
      end
      if (sel_mask) begin
         rdata_d = {4'h0, mask_q};
      end
      if (sel_state) begin
         rdata_d = {3'h0, masking_q, 2'b00, state_q};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Ready is a single pulse; a held access drops it for one cycle and is answered again
         pready <= first_acc;
         pslverr <= first_acc && !mapped;
      end
   end

   // Read data stands only in the cycle in which ready is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= word(rdata_d);
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // The state register is read-only; a write to it is dropped without error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_release_code_q <= 8'h00;
         second_release_code_q <= 8'h00;
         keypad_freeze_trigger_code_q <= 8'h00;
         freeze_timing_settings_q <= 8'h00;
         freeze_configuration_q <= 8'h00;
         mask_q <= 4'h0;
      end else if (wr) begin
         if (sel_first) begin
            first_release_code_q <= pwdata[7:0];
         end
         if (sel_second) begin
            second_release_code_q <= pwdata[7:0];
         end
         if (sel_freeze) begin
            keypad_freeze_trigger_code_q <= pwdata[7:0];
         end
         if (sel_timing) begin
            freeze_timing_settings_q <= pwdata[7:0];
         end
         if (sel_config) begin
            freeze_configuration_q <= {7'h00, pwdata[0]};
         end
         if (sel_mask) begin
            mask_q <= pwdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock sequencer
   reg [1:0] state_d;
   always @* begin
      state_d = state_q;
      unlock_done = 1'b0;
      ev_set = 4'h0;
      tick_restart = 1'b0;
      // Clearing the enable drops straight back to open from any state
      if (!lock_en) begin
         state_d = S_OPEN;
      end else begin
         case (state_q)
            S_OPEN: begin
               if (hitf) begin
                  state_d = S_LOCKED;
                  ev_set[`ST_FREEZE] = 1'b1;
               end
            end
            S_LOCKED: begin
               if (hit1) begin
                  state_d = S_HALF;
                  tick_restart = 1'b1;
               end
            end
            S_HALF: begin
               if (hit2) begin
                  state_d = S_OPEN;
                  unlock_done = 1'b1;
                  ev_set[`ST_UNLOCKED] = 1'b1;
               end else if (evt_valid) begin
                  state_d = S_LOCKED;
               end else if (win_secs != 3'b000 && sec_tick && win_q == 3'd1) begin
                  state_d = S_LOCKED;
               end
            end
            default: state_d = S_LOCKED;
         endcase
      end
      if (state_d == S_LOCKED && state_q == S_OPEN) begin
         ev_set[`ST_LOCK] = 1'b1;
      end
      // Interrupt on locked events, except the one that completes the unlock, unless the mask timer is running
      event_irq_fire = in_lock && evt_valid && mask_secs != 5'd0 && !masking_q
                       && !unlock_done;
      if (event_irq_fire) begin
         ev_set[`ST_EVENT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status: an event in the same cycle as its clear keeps the bit set
   wire [3:0] status_clr = (wr && sel_status) ? pwdata[3:0] : 4'h0;
   wire [3:0] status_d = (status_q & ~status_clr) | ev_set;

   // locked_q follows the next state, so it always agrees with state_q
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_OPEN;
         locked_q <= 1'b0;
      end else begin
         state_q <= state_d;
         locked_q <= (state_d != S_OPEN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unlock window: loaded on the first unlock event, counted down in seconds
   // A window of zero never expires: the count stays at zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q <= 3'd0;
      end else if (tick_restart) begin
         win_q <= win_secs;
      end else if (sec_tick && win_q != 3'd0) begin
         win_q <= win_q - 3'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt mask timer
   // Shares the one-second prescaler, so it may expire up to one second early
   // Zero in the field disables both the event interrupt and the mask
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         masking_q <= 1'b0;
         mtmr_q <= 5'd0;
      end else if (unlock_done || !lock_en) begin
         masking_q <= 1'b0;
         mtmr_q <= 5'd0;
      end else if (event_irq_fire) begin
         masking_q <= 1'b1;
         mtmr_q <= mask_secs;
      end else if (masking_q && sec_tick) begin
         if (mtmr_q <= 5'd1) begin
            masking_q <= 1'b0;
         end
         mtmr_q <= mtmr_q - 5'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, one-cycle event interrupt pulse and level interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 4'h0;
         event_irq_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         status_q <= status_d;
         event_irq_q <= event_irq_fire;
         // Taken from the next status so irq and status_q change together
         irq <= |(status_d & mask_q);
      end
   end
endmodule

// ---- lock_defines.vh ----
`ifndef LOCK_DEFINES_VH
`define LOCK_DEFINES_VH
`define IDX_FIRST_CODE 8'h33
`define IDX_SECOND_CODE 8'h34
`define IDX_FREEZE_CODE 8'h35
`define IDX_TIMING 8'h36
`define IDX_CONFIG 8'h37
`define IDX_STATUS 8'h38
`define IDX_MASK 8'h39
`define IDX_STATE 8'h3A
`define POL_BIT 7
`define EN_BIT 0
`define CODE_MSB 6
`define MASK_MSB 7
`define MASK_LSB 3
`define WIN_MSB 2
`define WIN_LSB 0
`define ST_LOCK 0
`define ST_EVENT 1
`define ST_FREEZE 2
`define ST_UNLOCKED 3
`define CLK_HZ 50000000
`define TICK_NS 1000000000
`define CLK_NS 20
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`endif

// ---- second_tick.v ----
module second_tick #(
   parameter [31:0] CYCLES = 32'd50000000
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Restart count from zero
   input wire restart,
   // One-cycle pulse per elapsed second
   output reg tick_q
);
   reg [31:0] cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (restart) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (cnt_q == CYCLES - 32'd1) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'd1;
         tick_q <= 1'b0;
      end
   end
endmodule

// ---- tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, locked_q, event_irq_q, irq;
   logic evt_valid, evt_state;
   logic [6:0] evt_code, c1, c2, cf, co;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   integer errors = 0, n_tests = 0, seed = 32'h81b6, i;
   keypad_lock_unlock #(.TICK_CYCLES(32'd20)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_valid(evt_valid),
      .evt_code(evt_code), .evt_state(evt_state), .locked_q(locked_q),
      .event_irq_q(event_irq_q), .irq(irq));
   event_source src_u (.pclk(pclk), .event_irq_q(event_irq_q), .evt_valid(evt_valid),
      .evt_code(evt_code), .evt_state(evt_state));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as it takes; only the watchdog ends a hung transfer
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // Only the enable bit of the configuration survives a write
   function logic [31:0] exp_rd(input logic [11:0] a, input logic [7:0] d);
      return (a == 12'h0DC) ? {31'b0, d[0]} : {24'b0, d};
   endfunction
   task test_done;
      $display("errors=%0d tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      test_done;
   end
   ////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         apb(0, 12'(12'h0CC + 4 * i), 0);
         chk(rd, 0);
      end
      for (i = 0; i < 5; i++) begin
         r = $random(seed);
         apb(1, 12'(12'h0CC + 4 * i), r);
         apb(0, 12'(12'h0CC + 4 * i), 0);
         chk(rd, exp_rd(12'(12'h0CC + 4 * i), r[7:0]));
      end
      apb(0, 12'h400, 0);
      chk(err, 1);
      r = $random(seed);
      c1 = r[6:0];
      c2 = c1 ^ 7'h01;
      cf = c1 ^ 7'h02;
      co = c1 ^ 7'h04;
      apb(1, 12'h0CC, {25'b0, c1});
      apb(1, 12'h0D0, {24'b0, 1'b1, c2});
      apb(1, 12'h0D4, {24'b0, 1'b1, cf});
      apb(1, 12'h0D8, 32'h0000_0011);
      apb(1, 12'h0DC, 32'h0000_0001);
      apb(1, 12'h0E4, 32'h0000_0005);
      src_u.send(cf, 1);
      chk(locked_q, 1);
      chk(irq, 1);
      apb(1, 12'h0E0, 32'h0000_000F);
      apb(0, 12'h0E0, 0);
      chk(rd, 0);
      chk(irq, 0);
      src_u.send(co, 1);
      chk(src_u.got_irq, 1);
      src_u.send(co, 1);
      chk(src_u.got_irq, 0);
      repeat (70) @(posedge pclk);
      src_u.send(co, 1);
      chk(src_u.got_irq, 1);
      src_u.send(c1, 0);
      repeat (30) @(posedge pclk);
      src_u.send(c2, 1);
      chk(locked_q, 1);
      src_u.send(c1, 0);
      src_u.send(co, 1);
      src_u.send(c2, 1);
      chk(locked_q, 1);
      src_u.send(c1, 1);
      src_u.send(c2, 1);
      chk(locked_q, 1);
      src_u.send(c1, 0);
      src_u.send(c2, 1);
      chk(locked_q, 0);
      apb(0, 12'h0E8, 0);
      chk(rd, 0);
      apb(0, 12'h0E0, 0);
      chk(rd, 32'h0000_000A);
      src_u.send(cf, 1);
      apb(1, 12'h0D8, 32'h0000_0010);
      src_u.send(c1, 0);
      repeat (60) @(posedge pclk);
      src_u.send(c2, 1);
      chk(locked_q, 0);
      src_u.send(cf, 0);
      chk(locked_q, 0);
      src_u.send(cf, 1);
      chk(locked_q, 1);
      apb(1, 12'h0D8, 0);
      src_u.send(co, 1);
      chk(src_u.got_irq, 0);
      apb(1, 12'h0DC, 0);
      repeat (2) @(posedge pclk);
      chk(locked_q, 0);
      test_done;
   end
endmodule
bind keypad_lock_unlock keypad_lock_checker chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .evt_valid(evt_valid),
   .locked_q(locked_q), .event_irq_q(event_irq_q), .irq(irq));
